// File: dv/can_buf_sva.sv
// checker on the carrier between host end and controller end
// assumes one pclk domain; instantiated beside the carrier in tb_top
`timescale 1ns/1ps
`include "can_fd_buffer_ordering_defines.svh"
module can_buf_sva
  import can_buf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // host to controller
  input wire logic init_req,
  input wire logic dbg_en,
  input wire logic [`SIZE_W-1:0] rx_size0,
  input wire logic [`SIZE_W-1:0] rx_size1,
  input wire logic [`ADDR_W-1:0] rx_start0,
  input wire logic [`ADDR_W-1:0] rx_start1,
  input wire logic [1:0] rx_ack,
  input wire logic txadd_wr,
  input wire logic [`NDED-1:0] txadd,
  input wire logic q_put,
  // controller to host
  input wire logic [1:0] dms,
  input wire logic dma_req,
  input wire logic [`ADDR_W-1:0] top0,
  input wire logic [`ADDR_W-1:0] top1,
  input wire logic [`NBUF-1:0] pending,
  input wire logic [2:0] put_idx,
  input wire logic q_full
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // dma state only reachable from the second step, request held with it
  dma_hold_a: assert property (dms == `DMS_DMA |-> dma_req &&
    ($past(dms) == `DMS_SECOND || $past(dms) == `DMS_DMA))
    else $error("dma request or state entry wrong");
  init_idle_a: assert property (init_req |=> dms == `DMS_IDLE)
    else $error("debug machine not idle after init request");
  dbg_off_a: assert property (!dbg_en |=> dms == `DMS_IDLE)
    else $error("debug machine left idle while unused");
  txadd_set_a: assert property (txadd_wr |=>
    (pending[7:0] & $past(txadd)) == $past(txadd))
    else $error("requested buffers not pending");
  qput_slot_a: assert property (q_put && !q_full |=> pending[8 + $past(put_idx)])
    else $error("queue put missed its slot");
  // put index decodes pending in the same cycle; stable pending only narrows when it is checked
  put_lowest_a: assert property ($stable(pending) && !q_full |->
    !pending[8 + put_idx] && ((~pending[15:8] & ((8'h01 << put_idx) - 8'h01)) == 8'h00))
    else $error("put index not lowest free slot");
  top_wrap_a: assert property (rx_ack[1] && rx_size1 == 7'h01 |-> ##2 top1 == rx_start1)
    else $error("one-element fifo pointer did not wrap");
  top_range_a: assert property (($stable(rx_start0) && $stable(rx_size0)) [*3] |->
    top0 >= rx_start0 && top0 - rx_start0 <= ({9'h000, rx_size0} - 16'h0001) * 16'h0012)
    else $error("top pointer outside fifo");
endmodule

// File: dv/tb_top.sv
// bench: host end and controller end joined by the carrier, apb master tasks
// assumes package, carrier and both design ends compiled first
`timescale 1ns/1ps
`include "can_fd_buffer_ordering_defines.svh"
module tb_top;
  import can_buf_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd_v;
  logic err_v;
  logic [5:0] ev_r;
  logic tx_valid;
  buf_idx_t tx_idx;
  msg_id_t tx_id;
  int mismatches;
  int check_count;

  can_buf_if bif();
  can_buf_host_end i_can_buf_host_end (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cif(bif));
  // event pulses: store0, store1, bus_off, dbg_msg, dma_done, tx_slot
  can_fd_buffer_ordering_logic i_can_fd_buffer_ordering_logic (.pclk(pclk),
    .presetn(presetn), .hif(bif), .rx_store(ev_r[1:0]), .bus_off(ev_r[2]),
    .dbg_msg(ev_r[3]), .dma_done(ev_r[4]), .tx_slot(ev_r[5]), .tx_valid(tx_valid),
    .tx_idx(tx_idx), .tx_id(tx_id));
  can_buf_sva i_can_buf_sva (.pclk(pclk), .presetn(presetn), .init_req(bif.init_req),
    .dbg_en(bif.dbg_en), .rx_size0(bif.rx_size0), .rx_size1(bif.rx_size1),
    .rx_start0(bif.rx_start0), .rx_start1(bif.rx_start1), .rx_ack(bif.rx_ack),
    .txadd_wr(bif.txadd_wr), .txadd(bif.txadd), .q_put(bif.q_put), .dms(bif.dms),
    .dma_req(bif.dma_req), .top0(bif.top0), .top1(bif.top1), .pending(bif.pending),
    .put_idx(bif.put_idx), .q_full(bif.q_full));

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, s, x);
    end
  endtask

  // one apb transfer; data and error taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) mismatches++;
    repeat (3) @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd_v, x);
  endtask

  task automatic ev(input logic [5:0] m);
    @(posedge pclk);
    ev_r <= m;
    @(posedge pclk);
    ev_r <= 6'h00;
    #1;
  endtask

  // tx_valid stands one cycle, looked at right after the taking edge
  task automatic snd(input buf_idx_t i, input msg_id_t id);
    ev(6'h20);
    chk({16'h0, tx_valid, tx_idx, tx_id}, {16'h0, 1'b1, i, id});
  endtask

  task automatic t_regs();
    rd(`REG_CTRL, {29'h0, `CTRL_RST});
    rd(`REG_STATUS, 32'h0);
    rd(12'h030, 32'h0);
    chk({31'h0, err_v}, 32'h1);
  endtask

  task automatic t_debug();
    wr(`REG_CTRL, 32'h4);
    repeat (3) ev(6'h08);
    rd(`REG_STATUS, 32'h7);
    wr(`REG_CTRL, 32'h6);
    rd(`REG_STATUS, 32'h7);
    ev(6'h10);
    ev(6'h08);
    rd(`REG_STATUS, 32'h1);
    wr(`REG_CTRL, 32'h5);
    rd(`REG_STATUS, 32'h0);
    wr(`REG_CTRL, 32'h4);
    repeat (2) ev(6'h08);
    rd(`REG_STATUS, 32'h2);
    ev(6'h04);
    rd(`REG_STATUS, 32'h0);
    wr(`REG_CTRL, 32'h0);
    ev(6'h08);
    rd(`REG_STATUS, 32'h0);
    wr(`REG_CTRL, 32'h4);
    ev(6'h08);
    rd(`REG_STATUS, 32'h1);
    // hardware reset in mid-run brings the machine from its first step back to idle
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_STATUS, 32'h0);
    rd(`REG_CTRL, {29'h0, `CTRL_RST});
    wr(`REG_CTRL, 32'h0);
  endtask

  task automatic t_rx();
    wr(`REG_RXCFG, 32'h0103);
    wr(`REG_RXSTART0, 32'h0100);
    wr(`REG_RXSTART1, 32'h0200);
    repeat (3) ev(6'h01);
    ev(6'h02);
    for (int k = 1; k < 4; k++) begin
      wr(`REG_RXACK, 32'h1);
      rd(`REG_TOP0, 32'h100 + 32'(k % 3) * 32'h12);
    end
    repeat (2) begin
      wr(`REG_RXACK, 32'h2);
      ev(6'h02);
      rd(`REG_TOP1, 32'h0200);
    end
  endtask

  // buffer 5 requested before 0,1,3; queue slot 8 shares the identifier
  task automatic t_order();
    for (int i = 1; i < 6; i += 2) wr(`REG_TXID, (32'(i) << 16) | 32'h0123);
    wr(`REG_TXID, 32'h0200);
    wr(`REG_TQPUT, 32'h0123);
    wr(`REG_TXADD, 32'h20);
    wr(`REG_TXADD, 32'h0B);
    snd(4'h1, 11'h123);
    snd(4'h3, 11'h123);
    ev(6'h20);
    chk({31'h0, tx_valid}, 32'h0);
    rd(`REG_TXDONE, 32'h101);
    rd(`REG_TXDONE, 32'h103);
    snd(4'h5, 11'h123);
    snd(4'h8, 11'h123);
    rd(`REG_TXDONE, 32'h105);
    rd(`REG_TXDONE, 32'h108);
    snd(4'h0, 11'h200);
    rd(`REG_TXDONE, 32'h100);
    rd(`REG_STATUS, 32'h0);
  endtask

  task automatic t_queue();
    repeat (3) wr(`REG_TQPUT, 32'h0050);
    rd(`REG_STATUS, 32'h00070030);
    snd(4'h8, 11'h050);
    rd(`REG_TXDONE, 32'h108);
    rd(`REG_STATUS, 32'h00060000);
    wr(`REG_TQPUT, 32'h0050);
    rd(`REG_STATUS, 32'h00070030);
    // fill the queue, then a refused put must leave slot 8 untouched
    repeat (5) wr(`REG_TQPUT, 32'h0060);
    rd(`REG_STATUS, 32'h00FF0080);
    wr(`REG_TQPUT, 32'h0070);
    snd(4'h8, 11'h050);
    rd(`REG_STATUS, 32'h00FE0000);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev_r = 6'h00;
    mismatches = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_debug();
    t_rx();
    t_order();
    t_queue();
    stop_test();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule

// File: pkg/can_buf_if.sv
// carrier between host end and controller buffer logic
// assumes both ends clocked by the same pclk
`timescale 1ns/1ps
`include "can_fd_buffer_ordering_defines.svh"
interface can_buf_if;
  import can_buf_pkg::*;
  logic init_req;
  logic cfg_chg_en;
  logic dbg_en;
  logic [`SIZE_W-1:0] rx_size0;
  logic [`SIZE_W-1:0] rx_size1;
  logic [`ADDR_W-1:0] rx_start0;
  logic [`ADDR_W-1:0] rx_start1;
  logic [1:0] rx_ack;
  logic txadd_wr;
  logic [`NDED-1:0] txadd;
  logic id_wr;
  buf_idx_t id_idx;
  msg_id_t id_val;
  logic q_put;
  msg_id_t q_id;
  logic done_ready;
  logic [1:0] dms;
  logic dma_req;
  logic [`ADDR_W-1:0] top0;
  logic [`ADDR_W-1:0] top1;
  logic [`NBUF-1:0] pending;
  logic [2:0] put_idx;
  logic q_full;
  logic done_valid;
  buf_idx_t done_idx;
  modport ctrl (
    input init_req, cfg_chg_en, dbg_en, rx_size0, rx_size1, rx_start0, rx_start1,
    input rx_ack, txadd_wr, txadd, id_wr, id_idx, id_val, q_put, q_id, done_ready,
    output dms, dma_req, top0, top1, pending, put_idx, q_full, done_valid, done_idx
  );
  modport host (
    output init_req, cfg_chg_en, dbg_en, rx_size0, rx_size1, rx_start0, rx_start1,
    output rx_ack, txadd_wr, txadd, id_wr, id_idx, id_val, q_put, q_id, done_ready,
    input dms, dma_req, top0, top1, pending, put_idx, q_full, done_valid, done_idx
  );
endinterface

// File: pkg/can_buf_pkg.sv
// types shared by both ends of the buffer ordering logic
// assumes the defines header is on the include path
package can_buf_pkg;
  `include "can_fd_buffer_ordering_defines.svh"
  typedef enum logic [3:0] {
    DBG_IDLE = 4'h1,
    DBG_FIRST = 4'h2,
    DBG_SECOND = 4'h4,
    DBG_DMA = 4'h8
  } dbg_state_t;
  typedef logic [`ID_W-1:0] msg_id_t;
  typedef logic [3:0] buf_idx_t;
endpackage

// File: pkg/can_fd_buffer_ordering_defines.svh
// constants for the message-buffer ordering logic and its host end
// assumes inclusion by bare name from package and design files
`ifndef CAN_FD_BUFFER_ORDERING_DEFINES_SVH
`define CAN_FD_BUFFER_ORDERING_DEFINES_SVH
`define NBUF 16
`define NDED 8
`define ID_W 11
`define ADDR_W 16
`define SIZE_W 7
`define ELEM_WORDS 16'h0012
`define DMS_IDLE 2'h0
`define DMS_FIRST 2'h1
`define DMS_SECOND 2'h2
`define DMS_DMA 2'h3
// host register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_RXCFG 12'h004
`define REG_RXSTART0 12'h008
`define REG_RXSTART1 12'h00C
`define REG_RXACK 12'h010
`define REG_TXADD 12'h014
`define REG_TXID 12'h018
`define REG_TQPUT 12'h01C
`define REG_STATUS 12'h020
`define REG_TOP0 12'h024
`define REG_TOP1 12'h028
`define REG_TXDONE 12'h02C
// field positions and the control reset value
`define CTRL_INIT 0
`define CTRL_CCE 1
`define CTRL_DBG 2
`define RXCFG_S1_LSB 8
`define TXID_IDX_LSB 16
`define ST_DMA 2
`define ST_PUT_LSB 4
`define ST_QFULL 7
`define ST_PEND_LSB 8
`define DONE_VALID 8
`define CTRL_RST 3'h1
`endif

// File: src/can_buf_host_end.sv
// host end: apb register slave driving the controller buffer logic
// assumes an apb master on pclk; one wait state on every access
`timescale 1ns/1ps
`include "can_fd_buffer_ordering_defines.svh"
module can_buf_host_end
  import can_buf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller side
  can_buf_if.host cif
);
  logic rdy_r;
  logic fire;
  logic wr;
  logic mapped;
  logic [2:0] ctrl_r;
  logic [31:0] rd_c;

  assign pready = rdy_r;
  assign fire = psel && penable && rdy_r;
  assign wr = fire && pwrite;

  // one wait state so read data leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r <= 1'b0;
    end else begin
      rdy_r <= psel && penable && !rdy_r;
    end
  end

  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_c = '0;
    unique case (paddr)
      `REG_CTRL: rd_c = {29'h0, ctrl_r};
      `REG_RXCFG: rd_c = {17'h0, cif.rx_size1, 1'b0, cif.rx_size0};
      `REG_RXSTART0: rd_c = {16'h0, cif.rx_start0};
      `REG_RXSTART1: rd_c = {16'h0, cif.rx_start1};
      `REG_RXACK, `REG_TXADD, `REG_TXID, `REG_TQPUT: rd_c = '0;
      `REG_STATUS: rd_c = {8'h0, cif.pending, cif.q_full, cif.put_idx, 1'b0,
                           cif.dma_req, cif.dms};
      `REG_TOP0: rd_c = {16'h0, cif.top0};
      `REG_TOP1: rd_c = {16'h0, cif.top1};
      `REG_TXDONE: rd_c = {23'h0, cif.done_valid, 4'h0, cif.done_idx};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel && penable && !rdy_r && !pwrite) ? rd_c : '0;
      pslverr <= psel && penable && !rdy_r && !mapped;
    end
  end

  // configuration registers; size one is accepted, software keeps two+
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RST;
      cif.rx_size0 <= '0;
      cif.rx_size1 <= '0;
      cif.rx_start0 <= '0;
      cif.rx_start1 <= '0;
    end else if (wr) begin
      if (paddr == `REG_CTRL) begin
        ctrl_r <= pwdata[2:0];
      end
      if (paddr == `REG_RXCFG) begin
        cif.rx_size0 <= pwdata[`SIZE_W-1:0];
        cif.rx_size1 <= pwdata[`RXCFG_S1_LSB +: `SIZE_W];
      end
      if (paddr == `REG_RXSTART0) begin
        cif.rx_start0 <= pwdata[`ADDR_W-1:0];
      end
      if (paddr == `REG_RXSTART1) begin
        cif.rx_start1 <= pwdata[`ADDR_W-1:0];
      end
    end
  end
  assign cif.init_req = ctrl_r[`CTRL_INIT];
  assign cif.cfg_chg_en = ctrl_r[`CTRL_CCE];
  assign cif.dbg_en = ctrl_r[`CTRL_DBG];

  // one-cycle command strobes taken at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.rx_ack <= '0;
      cif.txadd_wr <= 1'b0;
      cif.txadd <= '0;
      cif.id_wr <= 1'b0;
      cif.id_idx <= '0;
      cif.id_val <= '0;
      cif.q_put <= 1'b0;
      cif.q_id <= '0;
    end else begin
      cif.rx_ack <= (wr && paddr == `REG_RXACK) ? pwdata[1:0] : 2'h0;
      cif.txadd_wr <= wr && paddr == `REG_TXADD;
      cif.id_wr <= wr && paddr == `REG_TXID;
      cif.q_put <= wr && paddr == `REG_TQPUT;
      if (wr) begin
        cif.txadd <= pwdata[`NDED-1:0];
        cif.id_idx <= pwdata[`TXID_IDX_LSB +: 4];
        cif.id_val <= pwdata[`ID_W-1:0];
        cif.q_id <= pwdata[`ID_W-1:0];
      end
    end
  end

  // reading the sent-index register drains one entry
  assign cif.done_ready = fire && !pwrite && paddr == `REG_TXDONE;
endmodule

// File: src/can_fd_buffer_ordering_logic.sv
// controller end: rx fifo top pointers, debug message machine,
// tx buffer arbitration, tx queue put index, sent-index buffer
// assumes host end on the same pclk; event inputs are same-domain pulses
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "can_fd_buffer_ordering_defines.svh"
module can_fd_buffer_ordering_logic
  import can_buf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // host side
  can_buf_if.ctrl hif,
  // protocol engine events
  input wire logic [1:0] rx_store,
  input wire logic bus_off,
  input wire logic dbg_msg,
  input wire logic dma_done,
  input wire logic tx_slot,
  // chosen frame
  output logic tx_valid,
  output buf_idx_t tx_idx,
  output msg_id_t tx_id
);
  // get index wraps when it reaches the configured size, size one included
  function automatic logic [`SIZE_W-1:0] next_get(input logic [`SIZE_W-1:0] g,
                                                  input logic [`SIZE_W-1:0] s);
    logic [`SIZE_W:0] inc;
    inc = {1'b0, g} + {{`SIZE_W{1'b0}}, 1'b1};
    if (inc >= {1'b0, s}) begin
      next_get = '0;
    end else begin
      next_get = inc[`SIZE_W-1:0];
    end
  endfunction

  function automatic logic [`ADDR_W-1:0] top_addr(input logic [`ADDR_W-1:0] st,
                                                  input logic [`SIZE_W-1:0] g);
    logic [31:0] off;
    off = {25'h0, g} * {16'h0, `ELEM_WORDS};
    top_addr = st + off[`ADDR_W-1:0];
  endfunction

  logic [`SIZE_W-1:0] get_r [2];
  logic [`SIZE_W:0] fill_r [2];
  logic [`SIZE_W-1:0] sizes [2];
  assign sizes[0] = hif.rx_size0;
  assign sizes[1] = hif.rx_size1;

  // per fifo fill level and read position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        get_r[i] <= '0;
        fill_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic st;
        logic ak;
        st = rx_store[i] && (fill_r[i] < {1'b0, sizes[i]});
        ak = hif.rx_ack[i] && (fill_r[i] != '0);
        if (ak) begin
          get_r[i] <= next_get(get_r[i], sizes[i]);
        end
        fill_r[i] <= fill_r[i] + {{`SIZE_W{1'b0}}, st} - {{`SIZE_W{1'b0}}, ak};
      end
    end
  end

  // top pointers registered so the host sees stable addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hif.top0 <= '0;
      hif.top1 <= '0;
    end else begin
      hif.top0 <= top_addr(hif.rx_start0, get_r[0]);
      hif.top1 <= top_addr(hif.rx_start1, get_r[1]);
    end
  end

  // debug message machine; cce has no path here, so it cannot move status
  dbg_state_t dbg_r;
  dbg_state_t dbg_nxt;
  always_comb begin
    dbg_nxt = dbg_r;
    unique case (dbg_r)
      DBG_IDLE: if (dbg_msg) dbg_nxt = DBG_FIRST;
      DBG_FIRST: if (dbg_msg) dbg_nxt = DBG_SECOND;
      DBG_SECOND: if (dbg_msg) dbg_nxt = DBG_DMA;
      DBG_DMA: if (dma_done) dbg_nxt = DBG_IDLE;
      default: dbg_nxt = DBG_IDLE; // upset code falls back to idle
    endcase
    if (!hif.dbg_en) begin
      dbg_nxt = DBG_IDLE;
    end
    if (hif.init_req || bus_off) begin
      dbg_nxt = DBG_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_r <= DBG_IDLE;
    end else begin
      dbg_r <= dbg_nxt;
    end
  end

  // status field derives only from the machine state
  always_comb begin
    unique case (dbg_r)
      DBG_IDLE: hif.dms = `DMS_IDLE;
      DBG_FIRST: hif.dms = `DMS_FIRST;
      DBG_SECOND: hif.dms = `DMS_SECOND;
      DBG_DMA: hif.dms = `DMS_DMA;
      default: hif.dms = `DMS_IDLE;
    endcase
  end
  assign hif.dma_req = (hif.dms == `DMS_DMA);

  // identifiers and pending requests, dedicated 0..7, queue 8..15
  msg_id_t id_r [`NBUF];
  logic [`NBUF-1:0] pend_r;
  logic [2:0] put_c;
  logic qfree;

  // lowest free queue slot, never a rotating pointer
  always_comb begin
    put_c = '0;
    qfree = 1'b0;
    for (int i = `NDED - 1; i >= 0; i--) begin
      if (!pend_r[`NDED + i]) begin
        put_c = i[2:0];
        qfree = 1'b1;
      end
    end
  end
  assign hif.put_idx = put_c;
  assign hif.q_full = !qfree;

  // winner: lowest identifier, then lowest buffer index
  logic win_v;
  buf_idx_t win_i;
  always_comb begin
    win_v = 1'b0;
    win_i = '0;
    for (int i = 0; i < `NBUF; i++) begin
      if (pend_r[i] && (!win_v || id_r[i] < id_r[win_i])) begin
        win_v = 1'b1;
        win_i = i[3:0];
      end
    end
  end

  // two-entry buffer of sent indices; full stalls the transmit slot
  buf_idx_t dq_r [2];
  logic [1:0] dcnt_r;
  logic push;
  logic pop;
  assign push = tx_slot && win_v && (dcnt_r != 2'h2);
  assign pop = hif.done_valid && hif.done_ready;
  assign hif.done_valid = (dcnt_r != 2'h0);
  assign hif.done_idx = dq_r[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_r <= '0;
      dq_r[0] <= '0;
      dq_r[1] <= '0;
    end else begin
      dcnt_r <= dcnt_r + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        dq_r[0] <= dq_r[1];
      end
      if (push) begin
        if (dcnt_r == 2'h0 || (dcnt_r == 2'h1 && pop)) begin
          dq_r[0] <= win_i;
        end else begin
          dq_r[1] <= win_i;
        end
      end
    end
  end

  // identifier store and queue placement at the put index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NBUF; i++) begin
        id_r[i] <= '0;
      end
    end else begin
      if (hif.id_wr && !pend_r[hif.id_idx]) begin
        id_r[hif.id_idx] <= hif.id_val;
      end
      if (hif.q_put && qfree) begin
        id_r[{1'b1, put_c}] <= hif.q_id;
      end
    end
  end

  // pending bits: a request in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
    end else begin
      logic [`NBUF-1:0] set_v;
      logic [`NBUF-1:0] clr_v;
      set_v = '0;
      clr_v = '0;
      if (hif.txadd_wr) begin
        set_v[`NDED-1:0] = hif.txadd;
      end
      if (hif.q_put && qfree) begin
        set_v[{1'b1, put_c}] = 1'b1;
      end
      if (push) begin
        clr_v[win_i] = 1'b1;
      end
      if (hif.init_req) begin
        clr_v = '1;
      end
      pend_r <= (pend_r & ~clr_v) | set_v;
    end
  end
  assign hif.pending = pend_r;

  // chosen frame reported one cycle after the slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_idx <= '0;
      tx_id <= '0;
    end else begin
      tx_valid <= push;
      if (push) begin
        tx_idx <= win_i;
        tx_id <= id_r[win_i];
      end
    end
  end
endmodule
